// ==== rtl/rcc_pkg.sv ====
// Shared constants and types for the lane configuration register bank.
package rcc_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_RX_DETECT = 8'h40;
	localparam logic [7:0] ADDR_EQUALIZER = 8'h41;
	localparam logic [7:0] ADDR_SWING     = 8'h42;
	localparam logic [7:0] ADDR_DEEMPH    = 8'h43;

	// ----------------------------------------------------------------
	// Values after reset and field positions
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_RX_DETECT = 8'h00;
	localparam logic [7:0] RST_EQUALIZER = 8'h2F;
	localparam logic [7:0] RST_SWING     = 8'hAD;
	localparam logic [7:0] RST_DEEMPH    = 8'h02;
	localparam int         MODE_LSB      = 2;
	localparam int         SCP_BIT       = 7;
	localparam int         STATUS_BIT    = 7;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLOCK_FREQ_HZ        = 200_000_000;
	localparam int DETECT_PERIOD_MS     = 12;
	localparam int DETECT_WINDOW_MS     = 600;
	localparam int DETECT_PERIOD_CYCLES = DETECT_PERIOD_MS * (CLOCK_FREQ_HZ / 1000);
	localparam int DETECT_ATTEMPT_LIMIT = DETECT_WINDOW_MS / DETECT_PERIOD_MS;
	localparam int BYTE_BITS            = 8;

	// Bus address of this slave; the value is arbitrary.
	localparam logic [6:0] SMBUS_ADDR_DEFAULT = 7'h2A;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_HIZ          = 2'b00,
		MODE_AUTO_LIMITED = 2'b01,
		MODE_AUTO_ENDLESS = 2'b10,
		MODE_FIXED_50     = 2'b11
	} rcc_detect_mode_e;

	typedef enum logic [3:0] {
		SM_IDLE       = 4'h0,
		SM_ADDR       = 4'h1,
		SM_ADDR_ACK   = 4'h2,
		SM_CMD        = 4'h3,
		SM_CMD_ACK    = 4'h4,
		SM_WDATA      = 4'h5,
		SM_WDATA_ACK  = 4'h6,
		SM_RDATA      = 4'h7,
		SM_RDATA_ACK  = 4'h8,
		SM_WAIT_STOP  = 4'h9
	} rcc_bus_state_e;

endpackage

// ==== rtl/rcc_detect_if.sv ====
// Signals between the register bank and the receiver-detect sequencer.
`timescale 1ns/1ps
`default_nettype none
interface rcc_detect_if;
	import rcc_pkg::*;
	rcc_detect_mode_e mode;
	logic             receiver_present;
	logic             attempt;
	logic             terminated;
	modport ctrl (output mode, output receiver_present, input attempt, input terminated);
	modport seq  (input mode, input receiver_present, output attempt, output terminated);
endinterface
`default_nettype wire

// ==== rtl/rcc_detect_seq.sv ====
// Periodic far-end receiver detection and input termination control.
`timescale 1ns/1ps
`default_nettype none
module rcc_detect_seq
	import rcc_pkg::*;
#(
	parameter int PERIOD_CYCLES = DETECT_PERIOD_CYCLES
) (
	input wire logic clock,
	input wire logic reset,
	rcc_detect_if.seq dif
);
	localparam int TW = $clog2(PERIOD_CYCLES + 1);

	logic [TW-1:0]    timer;
	logic [5:0]       attempts;
	logic             found;
	logic             exhausted;
	rcc_detect_mode_e prev_mode;

	// A mode change restarts the whole detect sequence from scratch.
	wire restart   = (dif.mode != prev_mode);
	wire auto_mode = (dif.mode == MODE_AUTO_LIMITED) || (dif.mode == MODE_AUTO_ENDLESS);
	wire tick      = (timer == TW'(PERIOD_CYCLES - 1));
	wire may_try   = auto_mode && !found && !exhausted && !restart;

	always_ff @(posedge clock) begin
		if (reset) begin
			prev_mode <= MODE_HIZ;
		end else begin
			prev_mode <= dif.mode;
		end
	end

	always_ff @(posedge clock) begin
		if (reset || !may_try || tick) begin
			timer <= '0;
		end else begin
			timer <= timer + 1'b1; // [RQ3] [RQ4]
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			dif.attempt <= 1'b0;
		end else begin
			dif.attempt <= may_try && tick; // [RQ3] [RQ4]
		end
	end

	always_ff @(posedge clock) begin
		if (reset || restart) begin
			attempts  <= '0;
			found     <= 1'b0;
			exhausted <= 1'b0;
		end else if (may_try && tick) begin
			if (dif.receiver_present) begin
				found <= 1'b1; // [RQ5]
			end else begin
				attempts <= attempts + 1'b1;
				if (dif.mode == MODE_AUTO_LIMITED && attempts == 6'(DETECT_ATTEMPT_LIMIT - 1)) begin
					exhausted <= 1'b1; // [RQ3]
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			dif.terminated <= 1'b0;
		end else begin
			unique case (dif.mode)
				MODE_HIZ:          dif.terminated <= 1'b0; // [RQ2]
				MODE_FIXED_50:     dif.terminated <= 1'b1; // [RQ2]
				MODE_AUTO_LIMITED,
				MODE_AUTO_ENDLESS: dif.terminated <= found && !restart; // [RQ5]
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_hiz_mode: assert property (@(posedge clock) disable iff (reset) // [RQ2]
		dif.mode == MODE_HIZ && $past(dif.mode) == MODE_HIZ |-> !dif.terminated)
		else $error("input terminated in high impedance mode");
	a_fixed_term: assert property (@(posedge clock) disable iff (reset) // [RQ2]
		dif.mode == MODE_FIXED_50 && $past(dif.mode) == MODE_FIXED_50 |-> dif.terminated)
		else $error("input not terminated in fixed mode");
	a_attempt_limit: assert property (@(posedge clock) disable iff (reset) // [RQ3]
		dif.attempt && dif.mode == MODE_AUTO_LIMITED |-> attempts <= 6'(DETECT_ATTEMPT_LIMIT))
		else $error("detect attempts beyond the limit");
	a_endless_retry: assert property (@(posedge clock) disable iff (reset) // [RQ4]
		dif.mode == MODE_AUTO_ENDLESS && !restart && !found && tick |=> dif.attempt)
		else $error("endless mode skipped an attempt");
	a_hiz_until_found: assert property (@(posedge clock) disable iff (reset) // [RQ5]
		auto_mode && !found |=> !dif.terminated)
		else $error("terminated before detection");
	a_term_after_found: assert property (@(posedge clock) disable iff (reset) // [RQ5]
		may_try && tick && dif.receiver_present ##1 !restart |=> dif.terminated)
		else $error("no termination after detection");
	c_detect_found: cover property (@(posedge clock) disable iff (reset) $rose(found));
	c_detect_exhausted: cover property (@(posedge clock) disable iff (reset) $rose(exhausted));
endmodule
`default_nettype wire

// ==== rtl/rcc_lane_regs.sv ====
// SMBus slave register bank for one repeater lane with receiver detection.
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Overview of operation
// (RQ1) Host reads and writes this lane's registers over the SMBus slave.
// (RQ2) Detect mode 00 keeps input high impedance; 11 holds fixed 50-ohm termination.
// (RQ3) Mode 01 tries detection every 12 ms, stops after fifty failed attempts.
// (RQ4) Mode 10 tries detection every 12 ms without limit until found.
// (RQ5) Auto modes stay high impedance until found, then terminate at 50 ohm.
// (RQ6) Register mode governs only under global override; otherwise the pin governs.
// (RQ7) Eight-bit equalizer setting register resets to 0x2F.
// (RQ8) Swing register bit 7 enables short-circuit protection when set.
// (RQ9) Host always writes 0101 into swing register bits 6:3.
// (RQ10) Three-bit swing ratio code resets to 101.
// (RQ11) De-emphasis bit 7 reads one when terminated, zero when high impedance.
// (RQ12) Three-bit de-emphasis level resets to 010.
// (RQ13) Host writes zeros into reserved detect and de-emphasis fields.
// (RQ14) Writes to the termination status bit are ignored; reads show live state.
// ----------------------------------------------------------------
module rcc_lane_regs
	import rcc_pkg::*;
#(
	parameter int         DETECT_PERIOD = DETECT_PERIOD_CYCLES,
	parameter logic [6:0] SLAVE_ADDR    = SMBUS_ADDR_DEFAULT
) (
	input  wire logic       clock,
	input  wire logic       reset,
	input  wire logic       smbus_scl_in,
	input  wire logic       smbus_sda_in,
	output logic            smbus_sda_out,
	output logic            smbus_sda_oe,
	input  wire logic [1:0] pin_detect_mode,
	input  wire logic       detect_override,
	input  wire logic       receiver_present,
	output logic            detect_attempt,
	output logic            termination_state_flag,
	output logic [7:0]      equalizer_boost_setting,
	output logic [2:0]      output_swing_ratio,
	output logic            short_circuit_enable,
	output logic [2:0]      output_deemphasis_level
);

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic       scl_meta;
	logic       scl_sync;
	logic       scl_prev;
	logic       sda_meta;
	logic       sda_sync;
	logic       sda_prev;
	logic [1:0] pin_mode_meta;
	logic [1:0] pin_mode_sync;
	logic       override_meta;
	logic       override_sync;
	logic       present_meta;
	logic       present_sync;

	always_ff @(posedge clock) begin
		if (reset) begin
			scl_meta <= 1'b1;
			scl_sync <= 1'b1;
			scl_prev <= 1'b1;
			sda_meta <= 1'b1;
			sda_sync <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			scl_meta <= smbus_scl_in;
			scl_sync <= scl_meta;
			scl_prev <= scl_sync;
			sda_meta <= smbus_sda_in;
			sda_sync <= sda_meta;
			sda_prev <= sda_sync;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			pin_mode_meta <= 2'h0;
			pin_mode_sync <= 2'h0;
			override_meta <= 1'b0;
			override_sync <= 1'b0;
			present_meta  <= 1'b0;
			present_sync  <= 1'b0;
		end else begin
			pin_mode_meta <= pin_detect_mode;
			pin_mode_sync <= pin_mode_meta;
			override_meta <= detect_override;
			override_sync <= override_meta;
			present_meta  <= receiver_present;
			present_sync  <= present_meta;
		end
	end

	wire scl_rise   = scl_sync && !scl_prev;
	wire scl_fall   = !scl_sync && scl_prev;
	wire start_seen = scl_sync && scl_prev && sda_prev && !sda_sync;
	wire stop_seen  = scl_sync && scl_prev && !sda_prev && sda_sync;

	// ----------------------------------------------------------------
	// SMBus slave
	// ----------------------------------------------------------------
	rcc_bus_state_e state;
	logic [7:0]     shreg;
	logic [3:0]     bit_count;
	logic [7:0]     pointer;
	logic           read_mode;
	logic           master_ack;
	logic [7:0]     read_value;

	wire byte_done = scl_fall && (bit_count == 4'(BYTE_BITS));
	wire wr_strobe = (state == SM_WDATA) && byte_done;

	// The line is only ever pulled low; a one is sent by releasing it.
	always_ff @(posedge clock) begin
		if (reset) begin
			smbus_sda_out <= 1'b0;
		end else begin
			smbus_sda_out <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state        <= SM_IDLE;
			shreg        <= 8'h00;
			bit_count    <= 4'h0;
			pointer      <= 8'h00;
			read_mode    <= 1'b0;
			master_ack   <= 1'b0;
			smbus_sda_oe <= 1'b0;
		end else if (start_seen) begin
			state        <= SM_ADDR;
			bit_count    <= 4'h0;
			smbus_sda_oe <= 1'b0;
		end else if (stop_seen) begin
			state        <= SM_IDLE;
			smbus_sda_oe <= 1'b0;
		end else begin
			unique case (state)
				SM_IDLE, SM_WAIT_STOP: begin
					smbus_sda_oe <= 1'b0;
				end
				SM_ADDR, SM_CMD, SM_WDATA: begin
					if (scl_rise) begin
						shreg     <= {shreg[6:0], sda_sync};
						bit_count <= bit_count + 4'h1;
					end else if (byte_done) begin
						bit_count <= 4'h0;
						if (state == SM_ADDR) begin
							if (shreg[7:1] == SLAVE_ADDR) begin
								state        <= SM_ADDR_ACK; // [RQ1]
								read_mode    <= shreg[0];
								smbus_sda_oe <= 1'b1;
							end else begin
								state <= SM_WAIT_STOP;
							end
						end else if (state == SM_CMD) begin
							pointer      <= shreg;
							state        <= SM_CMD_ACK;
							smbus_sda_oe <= 1'b1;
						end else begin
							state        <= SM_WDATA_ACK;
							smbus_sda_oe <= 1'b1;
						end
					end
				end
				SM_ADDR_ACK: begin
					if (scl_fall && read_mode) begin
						state        <= SM_RDATA; // [RQ1]
						shreg        <= read_value;
						smbus_sda_oe <= !read_value[7];
						pointer      <= pointer + 8'h01;
					end else if (scl_fall) begin
						state        <= SM_CMD;
						smbus_sda_oe <= 1'b0;
					end
				end
				SM_CMD_ACK: begin
					if (scl_fall) begin
						state        <= SM_WDATA;
						smbus_sda_oe <= 1'b0;
					end
				end
				SM_WDATA_ACK: begin
					if (scl_fall) begin
						state        <= SM_WDATA;
						smbus_sda_oe <= 1'b0;
						pointer      <= pointer + 8'h01;
					end
				end
				SM_RDATA: begin
					if (scl_rise) begin
						bit_count <= bit_count + 4'h1;
					end else if (byte_done) begin
						state        <= SM_RDATA_ACK;
						bit_count    <= 4'h0;
						smbus_sda_oe <= 1'b0;
					end else if (scl_fall) begin
						shreg        <= {shreg[6:0], 1'b0};
						smbus_sda_oe <= !shreg[6];
					end
				end
				SM_RDATA_ACK: begin
					if (scl_rise) begin
						master_ack <= !sda_sync;
					end else if (scl_fall && master_ack) begin
						state        <= SM_RDATA;
						shreg        <= read_value;
						smbus_sda_oe <= !read_value[7];
						pointer      <= pointer + 8'h01;
					end else if (scl_fall) begin
						state <= SM_WAIT_STOP;
					end
				end
				default: begin
					state        <= SM_IDLE;
					smbus_sda_oe <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	rcc_detect_mode_e receiver_detect_mode;
	logic [7:0]       swing_reg;
	rcc_detect_if     dif ();

	always_ff @(posedge clock) begin
		if (reset) begin
			receiver_detect_mode    <= rcc_detect_mode_e'(RST_RX_DETECT[MODE_LSB +: 2]);
			equalizer_boost_setting <= RST_EQUALIZER; // [RQ7]
			swing_reg               <= RST_SWING; // [RQ10]
			output_deemphasis_level <= RST_DEEMPH[2:0]; // [RQ12]
		end else if (wr_strobe) begin
			unique case (pointer)
				ADDR_RX_DETECT: receiver_detect_mode <= rcc_detect_mode_e'(shreg[MODE_LSB +: 2]);
				ADDR_EQUALIZER: equalizer_boost_setting <= shreg; // [RQ7]
				ADDR_SWING: swing_reg <= shreg; // [RQ8] [RQ10]
				// Bit 7 here is status only, so the written value is dropped.
				ADDR_DEEMPH: output_deemphasis_level <= shreg[2:0]; // [RQ12] [RQ14]
				default: begin
				end
			endcase
		end
	end

	assign output_swing_ratio   = swing_reg[2:0];
	assign short_circuit_enable = swing_reg[SCP_BIT]; // [RQ8]

	// Unmapped offsets read as zero; reserved bits of stored fields read as zero.
	always_comb begin
		read_value = 8'h00;
		unique case (pointer)
			ADDR_RX_DETECT: read_value = {4'h0, receiver_detect_mode, 2'h0};
			ADDR_EQUALIZER: read_value = equalizer_boost_setting;
			ADDR_SWING:     read_value = swing_reg;
			ADDR_DEEMPH:    read_value = {dif.terminated, 4'h0, output_deemphasis_level}; // [RQ11]
			default:        read_value = 8'h00;
		endcase
	end

	// ----------------------------------------------------------------
	// Receiver detection
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (reset) begin
			dif.mode <= MODE_HIZ;
		end else begin
			dif.mode <= override_sync ? receiver_detect_mode
			                          : rcc_detect_mode_e'(pin_mode_sync); // [RQ6]
		end
	end

	assign dif.receiver_present   = present_sync;
	assign detect_attempt         = dif.attempt;
	assign termination_state_flag = dif.terminated; // [RQ11] [RQ14]

	rcc_detect_seq #(
		.PERIOD_CYCLES (DETECT_PERIOD)
	) u_detect (
		.clock (clock),
		.reset (reset),
		.dif   (dif.seq)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_addr_ack: assert property (@(posedge clock) disable iff (reset) // [RQ1]
		state == SM_ADDR && byte_done && !start_seen && !stop_seen
		&& shreg[7:1] == SLAVE_ADDR |=> smbus_sda_oe && state == SM_ADDR_ACK)
		else $error("own address not acknowledged");
	a_mode_select: assert property (@(posedge clock) disable iff (reset) // [RQ6]
		!$past(reset) |-> dif.mode == ($past(override_sync) ? $past(receiver_detect_mode)
		                                   : rcc_detect_mode_e'($past(pin_mode_sync))))
		else $error("wrong source for detect mode");
	a_reset_values: assert property (@(posedge clock) // [RQ7]
		$past(reset) |-> equalizer_boost_setting == RST_EQUALIZER
		&& output_swing_ratio == RST_SWING[2:0] && output_deemphasis_level == RST_DEEMPH[2:0])
		else $error("wrong value after reset");
	a_eq_write: assert property (@(posedge clock) disable iff (reset) // [RQ7]
		wr_strobe && pointer == ADDR_EQUALIZER && !start_seen && !stop_seen
		|=> equalizer_boost_setting == $past(shreg))
		else $error("equalizer write lost");
	a_scp_write: assert property (@(posedge clock) disable iff (reset) // [RQ8]
		wr_strobe && pointer == ADDR_SWING && !start_seen && !stop_seen
		|=> short_circuit_enable == $past(shreg[7]) && output_swing_ratio == $past(shreg[2:0]))
		else $error("swing write lost");
	a_status_read: assert property (@(posedge clock) disable iff (reset) // [RQ11]
		state == SM_ADDR_ACK && scl_fall && read_mode && pointer == ADDR_DEEMPH
		&& !start_seen && !stop_seen |=> shreg[STATUS_BIT] == $past(termination_state_flag))
		else $error("status bit does not follow termination");
	a_deemph_write: assert property (@(posedge clock) disable iff (reset) // [RQ12]
		wr_strobe && pointer == ADDR_DEEMPH && !start_seen && !stop_seen
		|=> output_deemphasis_level == $past(shreg[2:0]))
		else $error("de-emphasis write lost");
	c_reg_write: cover property (@(posedge clock) disable iff (reset) wr_strobe);
	c_reg_read: cover property (@(posedge clock) disable iff (reset)
		state == SM_RDATA_ACK && scl_fall && master_ack);
	c_terminated: cover property (@(posedge clock) disable iff (reset)
		$rose(termination_state_flag) && dif.mode == MODE_AUTO_ENDLESS);

endmodule
`default_nettype wire

// ==== tb/rcc_host_model.sv ====
// Bus master model that reaches the lane register bank over the two-wire bus.
`timescale 1ns/1ps
`default_nettype none
module rcc_host_model
	import rcc_pkg::*;
#(
	parameter int Q = 8
) (
	input  wire logic clock,
	input  wire logic sda_wire,
	output logic      scl,
	output logic      sda_pull
);
	// ----------------------------------------------------------------
	// Bit level
	// ----------------------------------------------------------------
	// Every change lands on a rising edge; SCL high and low phases of Q clocks
	// and a data setup of Q/2 keep well above the slave's minimum high, low and setup counts.
	initial begin
		scl      = 1'b1;
		sda_pull = 1'b0;
	end

	task automatic wait_q(input int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic put_bit(input logic b);
		sda_pull <= ~b;
		wait_q(Q / 2);
		scl <= 1'b1;
		wait_q(Q);
		scl <= 1'b0;
		wait_q(Q / 2);
	endtask

	task automatic get_bit(output logic b);
		sda_pull <= 1'b0;
		wait_q(Q / 2);
		scl <= 1'b1;
		wait_q(Q / 2);
		b = sda_wire;
		wait_q(Q / 2);
		scl <= 1'b0;
		wait_q(Q / 2);
	endtask

	// Data is released before SCL rises, so a slave still holding its
	// acknowledge cannot turn a repeated start into a stop.
	task automatic start_cond();
		sda_pull <= 1'b0;
		wait_q(Q / 2);
		scl <= 1'b1;
		wait_q(Q);
		sda_pull <= 1'b1;
		wait_q(Q);
		scl <= 1'b0;
		wait_q(Q / 2);
	endtask

	task automatic stop_cond();
		sda_pull <= 1'b1;
		wait_q(Q / 2);
		scl <= 1'b1;
		wait_q(Q);
		sda_pull <= 1'b0;
		wait_q(Q);
	endtask

	task automatic put_byte(input logic [7:0] v, inout logic ok);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			put_bit(v[i]);
		end
		get_bit(a);
		ok = ok & (a === 1'b0);
	endtask

	// ----------------------------------------------------------------
	// Register transfers
	// ----------------------------------------------------------------
	task automatic write_reg(input logic [6:0] addr, input logic [7:0] off,
		input logic [7:0] data, output logic ok);
		ok = 1'b1;
		@(posedge clock);
		start_cond();
		put_byte({addr, 1'b0}, ok);
		put_byte(off, ok);
		put_byte(data, ok);
		stop_cond();
	endtask

	task automatic read_reg(input logic [6:0] addr, input logic [7:0] off,
		output logic [7:0] data, output logic ok);
		ok = 1'b1;
		@(posedge clock);
		start_cond();
		put_byte({addr, 1'b0}, ok);
		put_byte(off, ok);
		start_cond();
		put_byte({addr, 1'b1}, ok);
		for (int i = 7; i >= 0; i--) begin
			get_bit(data[i]);
		end
		put_bit(1'b1);
		stop_cond();
	endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the lane register bank and its receiver detection.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) \
	begin \
		n_tests++; \
		if ((got) !== (exp)) begin \
			mismatches++; \
			$display("ERROR t=%0t %s", $time, msg); \
		end \
	end
module tb_top
	import rcc_pkg::*;
;
	localparam int PERIOD = 20;
	logic       clock;
	logic       reset;
	logic [1:0] pin_detect_mode;
	logic       detect_override;
	logic       receiver_present;
	logic       scl;
	logic       sda_pull;
	logic       sda_oe;
	logic       sda_out;
	logic       sda_wire;
	logic       detect_attempt;
	logic       term;
	logic [7:0] eq;
	logic [2:0] swing;
	logic       scp;
	logic [2:0] deemph;
	int         mismatches;
	int         n_tests;
	int         n;

	// Open-drain data line with a pull-up: low while either party pulls.
	assign sda_wire = ~sda_pull & (sda_oe ? sda_out : 1'b1);

	initial clock = 1'b0;
	always #2.5 clock = ~clock;

	rcc_lane_regs #(.DETECT_PERIOD(PERIOD), .SLAVE_ADDR(SMBUS_ADDR_DEFAULT)) dut (
		.clock(clock), .reset(reset), .smbus_scl_in(scl), .smbus_sda_in(sda_wire),
		.smbus_sda_out(sda_out), .smbus_sda_oe(sda_oe), .pin_detect_mode(pin_detect_mode),
		.detect_override(detect_override), .receiver_present(receiver_present),
		.detect_attempt(detect_attempt), .termination_state_flag(term),
		.equalizer_boost_setting(eq), .output_swing_ratio(swing),
		.short_circuit_enable(scp), .output_deemphasis_level(deemph));

	rcc_host_model #(.Q(8)) host (.clock(clock), .sda_wire(sda_wire), .scl(scl),
		.sda_pull(sda_pull));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic tally_and_finish();
		if (mismatches == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] off, input logic [7:0] data);
		logic ok;
		host.write_reg(SMBUS_ADDR_DEFAULT, off, data, ok);
		`CHK(ok, 1'b1, "write not acknowledged")
	endtask

	task automatic rd_chk(input logic [7:0] off, input logic [7:0] exp, input string msg);
		logic       ok;
		logic [7:0] v;
		host.read_reg(SMBUS_ADDR_DEFAULT, off, v, ok);
		`CHK(ok, 1'b1, "read not acknowledged")
		`CHK(v, exp, msg)
	endtask

	task automatic count_attempts(input int cycles, output int cnt);
		cnt = 0;
		repeat (cycles) begin
			@(posedge clock);
			#1;
			if (detect_attempt === 1'b1) begin
				cnt++;
			end
		end
	endtask

	// The mode register is loaded with the override off, so detection
	// restarts only when the override rises on a known edge.
	task automatic arm_mode(input logic [7:0] v);
		@(posedge clock);
		detect_override <= 1'b0;
		wr(ADDR_RX_DETECT, v);
		@(posedge clock);
		detect_override <= 1'b1;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_values();
		@(posedge clock);
		#1;
		`CHK(eq, 8'h2F, "equalizer reset value")
		`CHK(swing, 3'b101, "swing reset code")
		`CHK(scp, 1'b1, "protection reset value")
		`CHK(deemph, 3'b010, "de-emphasis reset code")
		`CHK(term, 1'b0, "terminated after reset")
		rd_chk(ADDR_RX_DETECT, 8'h00, "detect register reset");
		rd_chk(ADDR_EQUALIZER, 8'h2F, "equalizer register reset");
		rd_chk(ADDR_SWING, 8'hAD, "swing register reset");
		rd_chk(ADDR_DEEMPH, 8'h02, "de-emphasis register reset");
	endtask

	task automatic t_field_codes();
		for (int i = 0; i < 8; i++) begin
			wr(ADDR_SWING, {i[0], 4'b0101, i[2:0]});
			`CHK(swing, i[2:0], "swing code")
			`CHK(scp, i[0], "protection enable")
			wr(ADDR_DEEMPH, {1'b1, 4'b0000, i[2:0]});
			`CHK(deemph, i[2:0], "de-emphasis code")
			rd_chk(ADDR_DEEMPH, {5'b00000, i[2:0]}, "status bit took a write");
		end
		wr(ADDR_EQUALIZER, 8'h55);
		`CHK(eq, 8'h55, "equalizer output")
		rd_chk(ADDR_EQUALIZER, 8'h55, "equalizer readback");
		rd_chk(ADDR_SWING, 8'hAF, "swing readback");
	endtask

	task automatic t_foreign_address();
		logic ok;
		host.write_reg(SMBUS_ADDR_DEFAULT ^ 7'h01, ADDR_EQUALIZER, 8'hA5, ok);
		`CHK(ok, 1'b0, "foreign address acknowledged")
		`CHK(eq, 8'h55, "foreign write took effect")
		rd_chk(8'h44, 8'h00, "unmapped offset not zero");
	endtask

	task automatic t_fixed_modes();
		arm_mode(8'h0C);
		count_attempts(3 * PERIOD, n);
		`CHK(term, 1'b1, "fixed mode not terminated")
		`CHK(n, 0, "attempt in fixed mode")
		rd_chk(ADDR_DEEMPH, 8'h87, "status bit not set");
		arm_mode(8'h00);
		count_attempts(3 * PERIOD, n);
		`CHK(term, 1'b0, "high impedance mode terminated")
		`CHK(n, 0, "attempt in high impedance mode")
		rd_chk(ADDR_DEEMPH, 8'h07, "status bit not clear");
	endtask

	task automatic t_pin_governs();
		@(posedge clock);
		detect_override <= 1'b0;
		pin_detect_mode <= 2'b11;
		count_attempts(10, n);
		`CHK(term, 1'b1, "pin mode ignored")
		@(posedge clock);
		pin_detect_mode <= 2'b00;
		count_attempts(10, n);
		`CHK(term, 1'b0, "pin mode ignored")
	endtask

	task automatic t_auto_modes();
		logic found;
		arm_mode(8'h04);
		count_attempts(60 * PERIOD, n);
		`CHK(n, 50, "limited mode attempt count")
		`CHK(term, 1'b0, "terminated without receiver")
		arm_mode(8'h08);
		count_attempts(60 * PERIOD, n);
		`CHK(n, 59, "endless mode attempt count")
		`CHK(term, 1'b0, "terminated without receiver")
		@(posedge clock);
		receiver_present <= 1'b1;
		// Termination follows the successful attempt pulse by one clock.
		n = 0;
		found = 1'b0;
		for (int k = 0; k < 4 * PERIOD && !found; k++) begin
			@(posedge clock);
			#1;
			if (detect_attempt === 1'b1) begin
				n++;
			end
			found = (term === 1'b1);
		end
		`CHK(n, 1, "no single attempt found the receiver")
		`CHK(found, 1'b1, "not terminated after detection")
		if (!found) begin
			tally_and_finish();
		end
		count_attempts(5 * PERIOD, n);
		`CHK(n, 0, "attempts after detection")
		`CHK(term, 1'b1, "termination dropped")
		@(posedge clock);
		detect_override <= 1'b0;
		receiver_present <= 1'b0;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		mismatches = 0;
		n_tests = 0;
		reset = 1'b1;
		pin_detect_mode = 2'b00;
		detect_override = 1'b0;
		receiver_present = 1'b0;
		repeat (20) @(posedge clock);
		reset <= 1'b0;
		repeat (4) @(posedge clock);
		t_reset_values();
		t_field_codes();
		t_foreign_address();
		t_fixed_modes();
		t_pin_governs();
		t_auto_modes();
		tally_and_finish();
	end

	initial begin
		repeat (90000) @(posedge clock);
		mismatches++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
